// ==== design/pcsia_pkg.sv ====
// constants for the program and data address logic of the core
//==============================================================
package pcsia_pkg;
  // program counter layout
  localparam int PC_W        = 13;
  localparam int LOW_W       = 8;
  localparam int UPPER_W     = 5;
  localparam int BRANCH_W    = 11;
  localparam int PAGE_LSB    = 3;
  localparam int PAGE_MSB    = 4;
  localparam int PROG_WORDS  = 8192;
  localparam int SMALL_LIMIT = 4096;
  // reset and vector values
  localparam logic [PC_W-1:0]    RESET_PC   = 13'h0000;
  localparam logic [PC_W-1:0]    INT_VECTOR = 13'h0004;
  localparam logic [UPPER_W-1:0] RESET_LATCH = 5'h00;
  // return stack
  localparam int STACK_DEPTH = 8;
  // data addressing
  localparam int DADDR_W = 9;
  localparam int LOC_W   = 7;
  localparam int PTR_W   = 8;
  localparam logic [LOC_W-1:0] PORT_LOC   = 7'h00;
  localparam logic [PTR_W-1:0] RESET_PTR  = 8'h00;
  localparam logic [7:0]       ZERO_BYTE  = 8'h00;
  localparam logic [2:0]       RESET_BANK = 3'h0;
  // bank field positions inside the status byte write
  localparam int IND_BANK_POS = 2;
  localparam int DIR_BANK_HI  = 1;
endpackage : pcsia_pkg

// ==== design/pcsia_stack.sv ====
// circular return-address stack
`timescale 1ns/10ps
`default_nettype none
module pcsia_stack #(
  parameter int DEPTH = pcsia_pkg::STACK_DEPTH,
  parameter int WIDTH = pcsia_pkg::PC_W
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // stack actions
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [WIDTH-1:0] push_data,
  output logic      [WIDTH-1:0] top_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] entry [DEPTH];
  logic [PW-1:0]    ptr;
  logic [PW-1:0]    next_ptr;
  logic [PW-1:0]    top_idx;

  //==============================================================
  // pointer
  //==============================================================
  // wraps freely and has no flags, so no stack error is ever seen
  always_comb begin
    next_ptr = ptr;
    if (push) begin
      next_ptr = ptr + 1'b1;
    end else if (pop) begin
      next_ptr = ptr - 1'b1;
    end
  end

  // pointer is internal only, software cannot see it
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ptr <= '0;
    end else begin
      ptr <= next_ptr;
    end
  end

  assign top_idx  = ptr - 1'b1;
  assign top_data = entry[top_idx];

  //==============================================================
  // entries
  //==============================================================
  // a push on a full stack overwrites the oldest slot
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    logic [WIDTH-1:0] next_entry;
    always_comb begin
      next_entry = entry[i];
      if (push && ptr == PW'(i)) begin
        next_entry = push_data;
      end
    end
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        entry[i] <= '0;
      end else begin
        entry[i] <= next_entry;
      end
    end
  end
endmodule : pcsia_stack
`default_nettype wire

// ==== design/pcsia_daddr.sv ====
// data address former for direct and indirect access
`timescale 1ns/10ps
`default_nettype none
module pcsia_daddr (
  // operand selection
  input  wire logic [pcsia_pkg::LOC_W-1:0]   loc,
  input  wire logic [pcsia_pkg::PTR_W-1:0]   pointer_register,
  input  wire logic                          indirect_bank_bit,
  input  wire logic [1:0]                    direct_bank_bits,
  // formed address
  output logic      [pcsia_pkg::DADDR_W-1:0] addr,
  output logic                               indirect,
  output logic                               self_select
);
  //==============================================================
  // address forming
  //==============================================================
  // the port location itself holds nothing, it redirects
  always_comb begin
    indirect    = (loc == pcsia_pkg::PORT_LOC);
    self_select = indirect &&
                  (pointer_register == pcsia_pkg::RESET_PTR);
    if (indirect) begin
      addr = {indirect_bank_bit, pointer_register};
    end else begin
      addr = {direct_bank_bits, loc};
    end
  end
endmodule : pcsia_daddr
`default_nettype wire

// ==== design/pcsia_core.sv ====
// program counter, paging, return stack and data addressing
`timescale 1ns/10ps
`default_nettype none
module pcsia_core #(
  parameter int PROG_WORDS = pcsia_pkg::PROG_WORDS
) (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  // program flow requests from the sequencer
  input  wire logic                   pc_advance,
  input  wire logic                   low_write,
  input  wire logic [7:0]             low_data,
  input  wire logic                   latch_write,
  input  wire logic [7:0]             latch_data,
  input  wire logic                   call_req,
  input  wire logic                   goto_req,
  input  wire logic [10:0]            branch_target,
  input  wire logic                   return_req,
  input  wire logic                   int_vector_req,
  // pointer and bank bit writes
  input  wire logic                   pointer_write,
  input  wire logic [7:0]             pointer_data,
  input  wire logic                   bank_write,
  input  wire logic [2:0]             bank_data,
  // data access requests
  input  wire logic                   access_req,
  input  wire logic                   access_write,
  input  wire logic [6:0]             access_loc,
  // program side
  output logic      [12:0]            pc,
  output logic      [7:0]             pc_low_byte,
  output logic      [7:0]             latch_read,
  // data side
  output logic                        data_valid,
  output logic      [8:0]             data_addr,
  output logic                        data_write_en,
  output logic                        data_read_zero,
  output logic      [7:0]             pointer_read
);
  // small parts drop the top paging bit from call and goto targets
  localparam bit BIG_PART = (PROG_WORDS > pcsia_pkg::SMALL_LIMIT);

  logic [12:0] next_pc;
  logic [4:0]  pc_upper_bits;
  logic [4:0]  latch;
  logic [4:0]  next_latch;
  logic [1:0]  page_bits;
  logic        push;
  logic        pop;
  logic        sel_int;
  logic        sel_call;
  logic        sel_goto;
  logic        sel_ret;
  logic        sel_low;
  logic        sel_inc;
  logic [12:0] stack_top;

  logic [7:0]  pointer_register;
  logic [7:0]  next_pointer;
  logic        indirect_bank_bit;
  logic [1:0]  direct_bank_bits;
  logic [2:0]  next_bank;
  logic [8:0]  formed_addr;
  logic        is_indirect;
  logic        is_self;
  logic        next_valid;
  logic [8:0]  next_addr;
  logic        next_we;
  logic        next_zero;

  //==============================================================
  // program counter selection
  //==============================================================
  // one source per cycle; interrupt vectoring outranks everything
  always_comb begin
    sel_int  = int_vector_req;
    sel_call = !sel_int && call_req;
    sel_goto = !sel_int && !call_req && goto_req;
    sel_ret  = !sel_int && !call_req && !goto_req && return_req;
    sel_low  = !sel_int && !call_req && !goto_req && !return_req &&
               low_write;
    sel_inc  = !sel_int && !call_req && !goto_req && !return_req &&
               !low_write && pc_advance;
  end

  // page bits; latch bit 4 is masked from them on small parts but still loads pc[12] on low byte writes
  always_comb begin
    page_bits = {latch[pcsia_pkg::PAGE_MSB] & BIG_PART,
                 latch[pcsia_pkg::PAGE_LSB]};
  end

  // the sequencer hands over the already advanced counter for calls
  always_comb begin
    push    = sel_int || sel_call;
    pop     = sel_ret;
    next_pc = pc;
    if (sel_int) begin
      next_pc = pcsia_pkg::INT_VECTOR;
    end else if (sel_call || sel_goto) begin
      next_pc = {page_bits, branch_target};
    end else if (sel_ret) begin
      next_pc = stack_top;
    end else if (sel_low) begin
      next_pc = {latch, low_data};
    end else if (sel_inc) begin
      next_pc = pc + 13'h0001;
    end
  end

  // low byte arithmetic is done by the sequencer; no carry reaches
  // the upper bits on a low byte write because they come from the latch there; an advance does carry into them
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pc <= pcsia_pkg::RESET_PC;
    end else begin
      pc <= next_pc;
    end
  end

  assign pc_upper_bits = pc[12:8];
  assign pc_low_byte   = pc[7:0];

  //==============================================================
  // high-byte latch
  //==============================================================
  // only a direct write changes it, never the stack
  always_comb begin
    next_latch = latch;
    if (latch_write) begin
      next_latch = latch_data[4:0];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      latch <= pcsia_pkg::RESET_LATCH;
    end else begin
      latch <= next_latch;
    end
  end

  // unimplemented latch bits read as zero
  assign latch_read = {3'h0, latch};

  //==============================================================
  // return stack
  //==============================================================
  pcsia_stack #(
    .DEPTH (pcsia_pkg::STACK_DEPTH),
    .WIDTH (pcsia_pkg::PC_W)
  ) i_pcsia_stack (
    .core_clk  (core_clk),
    .reset     (reset),
    .push      (push),
    .pop       (pop),
    .push_data (pc),
    .top_data  (stack_top)
  );

  //==============================================================
  // pointer and bank bits
  //==============================================================
  // held here so the address former sees the values of this cycle
  always_comb begin
    next_pointer = pointer_register;
    next_bank    = {indirect_bank_bit, direct_bank_bits};
    if (pointer_write) begin
      next_pointer = pointer_data;
    end
    if (bank_write) begin
      next_bank = bank_data;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pointer_register  <= pcsia_pkg::RESET_PTR;
      indirect_bank_bit <= pcsia_pkg::RESET_BANK[pcsia_pkg::IND_BANK_POS];
      direct_bank_bits  <= pcsia_pkg::RESET_BANK[pcsia_pkg::DIR_BANK_HI:0];
    end else begin
      pointer_register  <= next_pointer;
      indirect_bank_bit <= next_bank[pcsia_pkg::IND_BANK_POS];
      direct_bank_bits  <= next_bank[pcsia_pkg::DIR_BANK_HI:0];
    end
  end

  assign pointer_read = pointer_register;

  //==============================================================
  // data access
  //==============================================================
  pcsia_daddr i_pcsia_daddr (
    .loc               (access_loc),
    .pointer_register  (pointer_register),
    .indirect_bank_bit (indirect_bank_bit),
    .direct_bank_bits  (direct_bank_bits),
    .addr              (formed_addr),
    .indirect          (is_indirect),
    .self_select       (is_self)
  );

  // a self-pointing access reads zero and writes nothing;
  // flag updates stay with the sequencer
  always_comb begin
    next_valid = access_req;
    next_addr  = formed_addr;
    next_we    = access_req && access_write && !is_self;
    next_zero  = access_req && !access_write && is_self;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      data_valid     <= 1'b0;
      data_addr      <= 9'h000;
      data_write_en  <= 1'b0;
      data_read_zero <= 1'b0;
    end else begin
      data_valid     <= next_valid;
      data_addr      <= next_addr;
      data_write_en  <= next_we;
      data_read_zero <= next_zero;
    end
  end

  //==============================================================
  // checks
  //==============================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_low_write;
    sel_low |=> pc_upper_bits == $past(latch) && pc_low_byte == $past(low_data);
  endproperty
  a_low_write: assert property (p_low_write)
    else $error("low byte write did not load upper bits from latch");

  property p_branch_page;
    (sel_goto || sel_call) |=>
      pc == {$past(page_bits), $past(branch_target)} &&
      pc[12] == ($past(latch[4]) & BIG_PART);
  endproperty
  a_branch_page: assert property (p_branch_page)
    else $error("branch target page bits wrong");

  sequence s_call;
    sel_call && !latch_write;
  endsequence
  sequence s_ret;
    sel_ret && !latch_write;
  endsequence
  property p_call_return;
    s_call ##1 s_ret |=> pc == $past(pc, 2) && latch == $past(latch, 2);
  endproperty
  a_call_return: assert property (p_call_return)
    else $error("return did not restore the saved counter");

  property p_latch_kept;
    (push || pop) && !latch_write |=> $stable(latch);
  endproperty
  a_latch_kept: assert property (p_latch_kept)
    else $error("stack action changed the latch");

  property p_int_vector;
    sel_int |=> pc == pcsia_pkg::INT_VECTOR;
  endproperty
  a_int_vector: assert property (p_int_vector)
    else $error("interrupt did not vector");

  property p_advance;
    sel_inc |=> pc == $past(pc) + 13'h0001;
  endproperty
  a_advance: assert property (p_advance)
    else $error("counter did not advance by one");

  property p_self_read;
    access_req && !access_write && access_loc == pcsia_pkg::PORT_LOC &&
      pointer_register == pcsia_pkg::RESET_PTR |=> data_read_zero;
  endproperty
  a_self_read: assert property (p_self_read)
    else $error("self-pointing read not forced to zero");

  property p_self_write;
    access_req && access_loc == pcsia_pkg::PORT_LOC &&
      pointer_register == pcsia_pkg::RESET_PTR |=> !data_write_en;
  endproperty
  a_self_write: assert property (p_self_write)
    else $error("self-pointing write was stored");

  property p_indirect_addr;
    access_req && access_loc == pcsia_pkg::PORT_LOC |=>
      data_addr == {$past(indirect_bank_bit), $past(pointer_register)};
  endproperty
  a_indirect_addr: assert property (p_indirect_addr)
    else $error("indirect address wrong");

  property p_direct_addr;
    access_req && access_loc != pcsia_pkg::PORT_LOC |=>
      data_addr == {$past(direct_bank_bits), $past(access_loc)} &&
      data_write_en == $past(access_write);
  endproperty
  a_direct_addr: assert property (p_direct_addr)
    else $error("direct address wrong");
endmodule : pcsia_core
`default_nettype wire

// ==== verification/pcsia_seq_model.sv ====
// sequencer model issuing one request per cycle to the core
`timescale 1ns/10ps
`default_nettype none
module pcsia_seq_model (
  // clock
  input  wire logic        core_clk,
  // program flow requests
  output logic             pc_advance,
  output logic             low_write,
  output logic [7:0]       low_data,
  output logic             latch_write,
  output logic [7:0]       latch_data,
  output logic             call_req,
  output logic             goto_req,
  output logic [10:0]      branch_target,
  output logic             return_req,
  output logic             int_vector_req,
  // pointer, bank and data access requests
  output logic             pointer_write,
  output logic [7:0]       pointer_data,
  output logic             bank_write,
  output logic [2:0]       bank_data,
  output logic             access_req,
  output logic             access_write,
  output logic [6:0]       access_loc
);
  // all quiet at time zero
  initial begin
    {pc_advance, low_write, latch_write, call_req, goto_req} = '0;
    {return_req, int_vector_req, pointer_write, bank_write} = '0;
    {access_req, access_write, low_data, latch_data} = '0;
    {branch_target, pointer_data, bank_data, access_loc} = '0;
  end
  //==============================================================
  // request issue
  //==============================================================
  // kinds: 1 advance, 2 low byte, 3 latch, 4 call, 5 goto, 6 return,
  // 7 vector, 8 pointer, 9 bank, A read, B write; one assignment per
  // signal per falling edge, so back-to-back calls never collide
  task automatic issue(input logic [3:0] kind, input logic [10:0] val);
    @(negedge core_clk);
    pc_advance     <= (kind == 4'h1);
    low_write      <= (kind == 4'h2); // table offsets kept in block
    low_data       <= val[7:0];
    latch_write    <= (kind == 4'h3); // page set before branching
    latch_data     <= val[7:0];
    call_req       <= (kind == 4'h4);
    goto_req       <= (kind == 4'h5);
    branch_target  <= val;
    return_req     <= (kind == 4'h6);
    int_vector_req <= (kind == 4'h7);
    pointer_write  <= (kind == 4'h8);
    pointer_data   <= val[7:0];
    bank_write     <= (kind == 4'h9);
    bank_data      <= val[2:0];
    access_req     <= (kind == 4'hA) || (kind == 4'hB);
    access_write   <= (kind == 4'hB);
    access_loc     <= val[6:0];
    @(posedge core_clk);
    #1;
  endtask : issue
endmodule : pcsia_seq_model
`default_nettype wire

// ==== verification/test_pcsia_core.sv ====
// self-checking bench for the program and data address logic
`timescale 1ns/10ps
`default_nettype none
module test_pcsia_core;
  // clock, reset and requests
  logic        core_clk;
  logic        reset;
  logic        pc_advance, low_write, latch_write, call_req, goto_req;
  logic        return_req, int_vector_req, pointer_write, bank_write;
  logic        access_req, access_write;
  logic [7:0]  low_data, latch_data, pointer_data;
  logic [10:0] branch_target;
  logic [2:0]  bank_data;
  logic [6:0]  access_loc;
  // observed outputs
  logic [12:0] pc, pc_small;
  logic [7:0]  pc_low_byte, latch_read, pointer_read;
  logic [8:0]  data_addr;
  logic        data_valid, data_write_en, data_read_zero;
  int          error_cnt = 0;
  int          samples_checked = 0;

  //==============================================================
  // clock and instances
  //==============================================================
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  pcsia_seq_model i_pcsia_seq_model (.core_clk(core_clk),
    .pc_advance(pc_advance), .low_write(low_write), .low_data(low_data),
    .latch_write(latch_write), .latch_data(latch_data),
    .call_req(call_req), .goto_req(goto_req),
    .branch_target(branch_target), .return_req(return_req),
    .int_vector_req(int_vector_req), .pointer_write(pointer_write),
    .pointer_data(pointer_data), .bank_write(bank_write),
    .bank_data(bank_data), .access_req(access_req),
    .access_write(access_write), .access_loc(access_loc));
  pcsia_core i_pcsia_core (.core_clk(core_clk), .reset(reset),
    .pc_advance(pc_advance), .low_write(low_write), .low_data(low_data),
    .latch_write(latch_write), .latch_data(latch_data),
    .call_req(call_req), .goto_req(goto_req),
    .branch_target(branch_target), .return_req(return_req),
    .int_vector_req(int_vector_req), .pointer_write(pointer_write),
    .pointer_data(pointer_data), .bank_write(bank_write),
    .bank_data(bank_data), .access_req(access_req),
    .access_write(access_write), .access_loc(access_loc), .pc(pc),
    .pc_low_byte(pc_low_byte), .latch_read(latch_read),
    .data_valid(data_valid), .data_addr(data_addr),
    .data_write_en(data_write_en), .data_read_zero(data_read_zero),
    .pointer_read(pointer_read));
  // smaller part: latch bit 4 must not page calls or gotos
  pcsia_core #(.PROG_WORDS(4096)) i_pcsia_core_small (
    .core_clk(core_clk), .reset(reset),
    .pc_advance(pc_advance), .low_write(low_write), .low_data(low_data),
    .latch_write(latch_write), .latch_data(latch_data),
    .call_req(call_req), .goto_req(goto_req),
    .branch_target(branch_target), .return_req(return_req),
    .int_vector_req(int_vector_req), .pointer_write(pointer_write),
    .pointer_data(pointer_data), .bank_write(bank_write),
    .bank_data(bank_data), .access_req(access_req),
    .access_write(access_write), .access_loc(access_loc), .pc(pc_small),
    .pc_low_byte(), .latch_read(), .data_valid(), .data_addr(),
    .data_write_en(), .data_read_zero(), .pointer_read());

  //==============================================================
  // shared tasks
  //==============================================================
  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic req(input logic [3:0] k, input logic [10:0] v);
    i_pcsia_seq_model.issue(k, v);
  endtask : req
  task automatic close_out;
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  //==============================================================
  // scenarios
  //==============================================================
  // low byte write pulls the upper bits from the latch
  task automatic t_low_write;
    req(4'h3, 11'h0FF);
    check({5'h00, latch_read}, 13'h001F);
    req(4'h2, 11'h034);
    check(pc, 13'h1F34);
    check({5'h00, pc_low_byte}, 13'h0034);
    req(4'h1, 11'h000);
    check(pc, 13'h1F35);
    $display("test low_write done");
  endtask : t_low_write
  // goto into each page; the small part drops latch bit 4
  task automatic t_paging;
    for (int p = 0; p < 4; p++) begin
      req(4'h3, {6'h00, p[1:0], 3'h4});
      req(4'h5, 11'h5A5);
      check(pc, {p[1:0], 11'h5A5});
      check(pc_small, {1'b0, p[0], 11'h5A5});
    end
    $display("test paging done");
  endtask : t_paging
  // nine nested calls wrap the stack; returns ignore a new latch
  task automatic t_stack;
    logic [12:0] pushed [9];
    req(4'h3, 11'h008);
    req(4'h5, 11'h123);
    for (int k = 0; k < 9; k++) begin
      pushed[k] = (k == 0) ? 13'h0923 : 13'h0A00 + 13'(k - 1);
      req(4'h4, 11'h200 + 11'(k));
      check(pc, 13'h0A00 + 13'(k));
    end
    req(4'h3, 11'h010);
    for (int j = 0; j < 9; j++) begin
      req(4'h6, 11'h000);
      check(pc, j < 8 ? pushed[8 - j] : pushed[8]);
    end
    check({5'h00, latch_read}, 13'h0010);
    req(4'h7, 11'h000);
    check(pc, 13'h0004);
    req(4'h1, 11'h000);
    req(4'h6, 11'h000);
    check(pc, pushed[8]);
    // call straight into return: page from latch bit 4, then full restore
    req(4'h4, 11'h300);
    check(pc, 13'h1300);
    check(pc_small, 13'h0300);
    req(4'h6, 11'h000);
    check(pc, pushed[8]);
    check({5'h00, latch_read}, 13'h0010);
    $display("test stack done");
  endtask : t_stack
  // indirect, self-selecting and direct accesses
  task automatic t_data;
    req(4'h8, 11'h020);
    req(4'h9, 11'h004);
    check({5'h00, pointer_read}, 13'h0020);
    req(4'hA, 11'h000);
    check({3'h0, data_valid, data_addr}, 13'h0320);
    check({data_write_en, data_read_zero}, 13'h0000);
    req(4'hB, 11'h000);
    check({12'h000, data_write_en}, 13'h0001);
    req(4'h8, 11'h000);
    check({12'h000, data_valid}, 13'h0000);
    req(4'hA, 11'h000);
    check({11'h000, data_valid, data_read_zero}, 13'h0003);
    req(4'hB, 11'h000);
    check({11'h000, data_valid, data_write_en}, 13'h0002);
    req(4'h9, 11'h002);
    req(4'hB, 11'h045);
    check({3'h0, data_write_en, data_addr}, 13'h0345);
    $display("test data done");
  endtask : t_data
  // reset in mid-run clears the counter and latch at once
  task automatic t_mid_reset;
    req(4'h3, 11'h018);
    req(4'h2, 11'h077);
    req(4'h0, 11'h7FF);
    @(negedge core_clk);
    reset <= 1'b1;
    #2;
    check(pc, 13'h0000);
    check({5'h00, latch_read}, 13'h0000);
    @(negedge core_clk);
    reset <= 1'b0;
    req(4'h1, 11'h000);
    check(pc, 13'h0001);
    $display("test mid_reset done");
  endtask : t_mid_reset

  //==============================================================
  // main sequence and watchdog
  //==============================================================
  initial begin
    reset = 1'b1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    reset <= 1'b0;
    check(pc, 13'h0000);
    t_low_write();
    t_paging();
    t_stack();
    t_data();
    t_mid_reset();
    req(4'h0, 11'h000);
    close_out();
  end
  // tests need about 60 cycles; allow many times that
  initial begin
    #20000;
    error_cnt++;
    close_out();
  end
endmodule : test_pcsia_core
`default_nettype wire
